// File: hdl/lscpe_pkg.sv
// constants for the line scan and cp-bit error counter register bank
package lscpe_pkg;
  localparam logic [7:0] ADDR_LINE_SCAN = 8'h73;
  localparam logic [7:0] ADDR_EVT_HIGH  = 8'h74;
  localparam logic [7:0] ADDR_EVT_LOW   = 8'h75;
  localparam logic [7:0] ADDR_SEC_HIGH  = 8'h76;
  localparam logic [7:0] ADDR_SEC_LOW   = 8'h77;
  localparam logic [7:0] ADDR_UNUSED_LO = 8'h78;
  localparam logic [7:0] ADDR_UNUSED_HI = 8'h85;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h86;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h87;
  localparam int         SCAN_LOS_BIT   = 0;
  localparam int         SCAN_LOL_BIT   = 1;
  localparam int         SCAN_DMO_BIT   = 2;
  localparam int         IRQ_LOS_BIT    = 0;
  localparam int         IRQ_LOL_BIT    = 1;
  localparam int         IRQ_SEC_BIT    = 2;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [15:0] RESET_COUNT   = 16'h0000;
  localparam int         CLK_HZ         = 20000000;
  localparam int         ONE_SECOND_MS  = 1000;
  localparam int         SEC_CYCLES     = CLK_HZ / 1000 * ONE_SECOND_MS;
endpackage : lscpe_pkg

// File: hdl/lscpe_pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module lscpe_pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level only follows once two settled stages agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_out <= 1'b0;
    end else if (clk_en && (s2_reg == s3_reg)) begin
      level_out <= s3_reg;
    end
  end
endmodule : lscpe_pin_sync
`default_nettype wire

// File: hdl/lscpe_sec_timer.sv
// free-running one-second tick generator
`timescale 1ns/100ps
`default_nettype none
module lscpe_sec_timer #(
  parameter int SEC_CYCLES = lscpe_pkg::SEC_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  output logic      tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (clk_en) begin
      if (cnt_reg == 32'(SEC_CYCLES - 1)) begin
        cnt_reg <= 32'h0;
        tick    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
        tick    <= 1'b0;
      end
    end
  end
endmodule : lscpe_sec_timer
`default_nettype wire

// File: hdl/lscpe_top.sv
// line scan register and cp-bit error counter register bank
// Summary of operation
// R1: scan bit 1 reads the level of the receive lock loss pin.
// R2: scan bit 0 reads the level of the receive signal loss pin.
// R3: a high signal loss pin makes the device declare loss of signal itself.
// R4: scan bits reflect their pins through the three-stage synchroniser and agreement filter only.
// R5: a 16-bit error event counter is kept as high and low clear-on-read bytes, reset zero.
// R6: the event counter counts errors since the last read, saturating at 0xffff, and restarts after it.
// R7: event counter high byte sits at 0x74 and low byte at 0x75.
// R8: a read-only 16-bit accumulator holds the last full one-second error count, reset zero.
// R9: accumulator high byte sits at 0x76 and low byte at 0x77.
// R10: addresses 0x78 to 0x85 are unused and carry no function.
// R11: each second the running count moves to the accumulator and restarts.
`timescale 1ns/100ps
`default_nettype none
module lscpe_top #(
  parameter int SEC_CYCLES = lscpe_pkg::SEC_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rd_data,
  input  wire logic       receive_lock_loss_pin,
  input  wire logic       receive_signal_loss_pin,
  input  wire logic       dmo_pin,
  input  wire logic       cpbit_error,
  output logic            los_declared,
  output logic            irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic       lol_sync;
  logic       los_sync;
  logic       dmo_sync;
  logic       sec_tick;
  logic       los_prev_reg;
  logic       lol_prev_reg;
  logic [15:0] evt_reg;
  logic [15:0] run_reg;
  logic [15:0] sec_reg;
  logic [7:0] evt_low_hold_reg;
  logic       low_held_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic [2:0] stat_set;
  logic [7:0] scan_byte;
  logic       rd_evt_high;
  logic       rd_evt_low;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : sat_inc

  lscpe_pin_sync u_lol (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (receive_lock_loss_pin),
    .level_out (lol_sync)
  );

  lscpe_pin_sync u_los (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (receive_signal_loss_pin),
    .level_out (los_sync)
  );

  lscpe_pin_sync u_dmo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (dmo_pin),
    .level_out (dmo_sync)
  );

  lscpe_sec_timer #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_sec (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .tick    (sec_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // scan byte: pins straight through, only the synchroniser in the path
  always_comb begin
    scan_byte = 8'h00;
    scan_byte[lscpe_pkg::SCAN_LOL_BIT] = lol_sync; // [R1] [R4]
    scan_byte[lscpe_pkg::SCAN_LOS_BIT] = los_sync; // [R2] [R4]
    scan_byte[lscpe_pkg::SCAN_DMO_BIT] = dmo_sync; // [R4]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      los_declared <= 1'b0;
    end else if (clk_en) begin
      los_declared <= los_sync; // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rd_evt_high = rd_stb && (addr == lscpe_pkg::ADDR_EVT_HIGH);
  assign rd_evt_low  = rd_stb && (addr == lscpe_pkg::ADDR_EVT_LOW);

  // event counter; a high-byte read snapshots the low byte so the pair is coherent.
  // an error in the clearing cycle is kept as the new count of one.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_reg <= lscpe_pkg::RESET_COUNT; // [R5]
    end else if (clk_en) begin
      if (rd_evt_high || (rd_evt_low && !low_held_reg)) begin
        evt_reg <= cpbit_error ? 16'h0001 : 16'h0000; // [R6]
      end else if (cpbit_error) begin
        evt_reg <= sat_inc(evt_reg); // [R6]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_low_hold_reg <= lscpe_pkg::RESET_BYTE;
      low_held_reg     <= 1'b0;
    end else if (clk_en) begin
      if (rd_evt_high) begin
        evt_low_hold_reg <= evt_reg[7:0];
        low_held_reg     <= 1'b1;
      end else if (rd_evt_low) begin
        low_held_reg <= 1'b0;
      end
    end
  end

  // running one-second count and its accumulator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_reg <= lscpe_pkg::RESET_COUNT;
      sec_reg <= lscpe_pkg::RESET_COUNT; // [R8]
    end else if (clk_en) begin
      if (sec_tick) begin
        sec_reg <= cpbit_error ? sat_inc(run_reg) : run_reg; // [R11]
        run_reg <= 16'h0000; // [R11]
      end else if (cpbit_error) begin
        run_reg <= sat_inc(run_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: rising loss of signal, rising loss of lock, second done
  assign stat_set = {sec_tick,
                     lol_sync && !lol_prev_reg,
                     los_sync && !los_prev_reg};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      los_prev_reg <= 1'b0;
      lol_prev_reg <= 1'b0;
    end else if (clk_en) begin
      los_prev_reg <= los_sync;
      lol_prev_reg <= lol_sync;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= 3'h0;
    end else if (clk_en) begin
      // set wins over a write-one clear in the same cycle
      if (wr_stb && addr == lscpe_pkg::ADDR_IRQ_STAT) begin
        stat_reg <= (stat_reg & ~wr_data[2:0]) | stat_set;
      end else begin
        stat_reg <= stat_reg | stat_set;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= 3'h0;
    end else if (clk_en && wr_stb && addr == lscpe_pkg::ADDR_IRQ_MASK) begin
      mask_reg <= wr_data[2:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped and unused addresses read as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      rd_data <= 8'h00;
      if (rd_stb) begin
        case (addr)
          lscpe_pkg::ADDR_LINE_SCAN: rd_data <= scan_byte;
          lscpe_pkg::ADDR_EVT_HIGH:  rd_data <= evt_reg[15:8]; // [R7]
          lscpe_pkg::ADDR_EVT_LOW:   rd_data <= low_held_reg ? evt_low_hold_reg
                                                             : evt_reg[7:0]; // [R7]
          lscpe_pkg::ADDR_SEC_HIGH:  rd_data <= sec_reg[15:8]; // [R9]
          lscpe_pkg::ADDR_SEC_LOW:   rd_data <= sec_reg[7:0]; // [R9]
          lscpe_pkg::ADDR_IRQ_STAT:  rd_data <= {5'h00, stat_reg};
          lscpe_pkg::ADDR_IRQ_MASK:  rd_data <= {5'h00, mask_reg};
          default:                   rd_data <= 8'h00; // [R10]
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_scan_lol;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_stb && addr == lscpe_pkg::ADDR_LINE_SCAN)
        |=> (rd_data[1] == $past(lol_sync));
  endproperty
  a_scan_lol: assert property (p_scan_lol) else $error("scan bit 1 wrong"); // [R1]

  property p_scan_los;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_stb && addr == lscpe_pkg::ADDR_LINE_SCAN)
        |=> (rd_data[0] == $past(los_sync));
  endproperty
  a_scan_los: assert property (p_scan_los) else $error("scan bit 0 wrong"); // [R2]

  property p_los_decl;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && los_sync) |=> los_declared;
  endproperty
  a_los_decl: assert property (p_los_decl) else $error("loss of signal not declared"); // [R3]

  property p_scan_upper;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_stb && addr == lscpe_pkg::ADDR_LINE_SCAN) |=> (rd_data[7:3] == 5'h00);
  endproperty
  a_scan_upper: assert property (p_scan_upper) else $error("scan upper bits set"); // [R4]

  property p_evt_clear;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_evt_high && !cpbit_error) |=> (evt_reg == 16'h0000);
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event count not cleared"); // [R5]

  property p_evt_count;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cpbit_error && !rd_evt_high && !rd_evt_low && evt_reg != 16'hffff)
        |=> (evt_reg == $past(evt_reg) + 16'h0001);
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("event not counted"); // [R6]

  property p_evt_read;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_evt_high) |=> (rd_data == $past(evt_reg[15:8]));
  endproperty
  a_evt_read: assert property (p_evt_read) else $error("event high byte wrong"); // [R7]

  property p_sec_hold;
    @(posedge sys_clk) disable iff (rst)
      (!sec_tick) |=> (sec_reg == $past(sec_reg));
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("accumulator moved"); // [R8]

  property p_sec_read;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_stb && addr == lscpe_pkg::ADDR_SEC_LOW) |=> (rd_data == $past(sec_reg[7:0]));
  endproperty
  a_sec_read: assert property (p_sec_read) else $error("accumulator low byte wrong"); // [R9]

  property p_unused;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_stb && addr >= lscpe_pkg::ADDR_UNUSED_LO
       && addr <= lscpe_pkg::ADDR_UNUSED_HI) |=> (rd_data == 8'h00);
  endproperty
  a_unused: assert property (p_unused) else $error("unused address read nonzero"); // [R10]

  property p_sec_load;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && sec_tick && !cpbit_error) |=> (sec_reg == $past(run_reg) && run_reg == 16'h0000);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("second transfer wrong"); // [R11]

  // the low byte after a high-byte read must be the snapshot, not the live count
  property p_evt_snap;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_evt_low && low_held_reg)
        |=> (rd_data == $past(evt_low_hold_reg));
  endproperty
  a_evt_snap: assert property (p_evt_snap) else $error("event low snapshot wrong"); // [R7]

  property p_sec_read_high;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && rd_stb && addr == lscpe_pkg::ADDR_SEC_HIGH)
        |=> (rd_data == $past(sec_reg[15:8]));
  endproperty
  a_sec_read_high: assert property (p_sec_read_high) else $error("accumulator high byte wrong"); // [R9]
endmodule : lscpe_top
`default_nettype wire

// File: test/lscpe_liu_model.sv
// behavioural line interface unit driving the scanned pins and error pulses
`timescale 1ns/100ps
`default_nettype none
module lscpe_liu_model (
  input  wire logic sys_clk,
  output logic      receive_lock_loss_pin,
  output logic      receive_signal_loss_pin,
  output logic      dmo_pin,
  output logic      cpbit_error
);
  initial begin
    receive_lock_loss_pin   = 1'b0;
    receive_signal_loss_pin = 1'b0;
    dmo_pin                 = 1'b0;
    cpbit_error             = 1'b0;
  end

  // pins move right after an edge; the synchroniser absorbs any phase
  task set_pins(input logic lol, input logic los, input logic dmo);
    @(posedge sys_clk);
    receive_lock_loss_pin   <= lol;
    receive_signal_loss_pin <= los;
    dmo_pin                 <= dmo;
  endtask : set_pins

  // back to back pulses, one error per cycle
  task send_errors(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      cpbit_error <= 1'b1;
    end
    @(posedge sys_clk);
    cpbit_error <= 1'b0;
  endtask : send_errors
endmodule : lscpe_liu_model
`default_nettype wire

// File: test/lscpe_bench.sv
// self-checking bench for the line scan and error counter register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module lscpe_bench;
  logic       sys_clk = 1'b0;
  logic       rst     = 1'b1;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_stb  = 1'b0;
  logic       rd_stb  = 1'b0;
  logic       en      = 1'b1;
  logic [7:0] rd_data;
  logic       lol, los, dmo, err, los_declared, irq;
  int         n_fail      = 0;
  int         check_count = 0;
  logic [7:0] d;

  always #25 sys_clk = ~sys_clk;

  lscpe_liu_model liu_u (.sys_clk(sys_clk), .receive_lock_loss_pin(lol),
    .receive_signal_loss_pin(los), .dmo_pin(dmo), .cpbit_error(err));

  // short second keeps the accumulator test fast
  lscpe_top #(.SEC_CYCLES(400)) dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(en),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .receive_lock_loss_pin(lol), .receive_signal_loss_pin(los), .dmo_pin(dmo),
    .cpbit_error(err), .los_declared(los_declared), .irq(irq));

  task final_report;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a; wr_data <= v; wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask : rd

  task wait_irq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 600) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    if (irq !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : wait_irq

  task t_reset_and_unused;
    rd(8'h74, d); `CHK(d, 8'h00)
    rd(8'h75, d); `CHK(d, 8'h00)
    rd(8'h76, d); `CHK(d, 8'h00)
    rd(8'h77, d); `CHK(d, 8'h00)
    wr(8'h78, 8'ha5); wr(8'h85, 8'h5a); wr(8'h77, 8'hff);
    rd(8'h78, d); `CHK(d, 8'h00)
    rd(8'h85, d); `CHK(d, 8'h00)
    rd(8'h77, d); `CHK(d, 8'h00)
    repeat (450) @(posedge sys_clk);
    `CHK(irq, 1'b0)
  endtask : t_reset_and_unused

  task t_pins;
    liu_u.set_pins(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    rd(8'h73, d); `CHK(d, 8'h02)
    `CHK(los_declared, 1'b0)
    liu_u.set_pins(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge sys_clk);
    rd(8'h73, d); `CHK(d, 8'h05)
    `CHK(los_declared, 1'b1)
    rd(8'h86, d); `CHK(d & 8'h03, 8'h03)
    liu_u.set_pins(1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    rd(8'h73, d); `CHK(d, 8'h00)
    `CHK(los_declared, 1'b0)
  endtask : t_pins

  task t_event_counter;
    liu_u.send_errors(300);
    rd(8'h74, d); `CHK(d, 8'h01)
    rd(8'h75, d); `CHK(d, 8'h2c)
    rd(8'h74, d); `CHK(d, 8'h00)
    rd(8'h75, d); `CHK(d, 8'h00)
    liu_u.send_errors(3);
    rd(8'h75, d); `CHK(d, 8'h03)
    rd(8'h75, d); `CHK(d, 8'h00)
    // a frozen clock enable must drop these errors
    @(posedge sys_clk) en <= 1'b0;
    liu_u.send_errors(5);
    @(posedge sys_clk) en <= 1'b1;
    rd(8'h75, d); `CHK(d, 8'h00)
  endtask : t_event_counter

  task t_accumulator;
    wr(8'h86, 8'hff);
    wr(8'h87, 8'h04);
    wait_irq();
    wr(8'h86, 8'h04);
    liu_u.send_errors(260);
    `CHK(irq, 1'b0)
    wait_irq();
    rd(8'h76, d); `CHK(d, 8'h01)
    rd(8'h77, d); `CHK(d, 8'h04)
    rd(8'h77, d); `CHK(d, 8'h04)
    wr(8'h87, 8'h00);
    wr(8'h86, 8'hff);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
  endtask : t_accumulator

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_and_unused();
    t_pins();
    t_event_counter();
    t_accumulator();
    final_report();
  end
endmodule : lscpe_bench
`undef CHK
`default_nettype wire
